// ==== core/rma_pkg.sv ====
// package: shared types and constants for the ratemeter alarm logic
package rma_pkg;

    // ****************************************
    // rate encoding: value in hundredths of mR/h
    // ****************************************
    localparam int RATE_W = 32;
    localparam logic [31:0] UNDER_DEFAULT = 32'h0000_000A; // 1.00E-1 mR/h
    localparam logic [31:0] UNDER_MIN = 32'h0000_0001;     // 1.00E-2 mR/h
    localparam logic [31:0] UNDER_MAX = 32'h0000_0064;     // 1.00E0 mR/h
    localparam logic [31:0] OVER_MAX = 32'h0098_9680;      // 1.00E5 mR/h
    localparam logic [31:0] OVER_DEFAULT = 32'h0001_86A0;  // 1.00E3 mR/h

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ = 25_000_000;
    localparam int TRIP_MS = 1000;   // longest alarm trip latency
    localparam int FREEZE_S = 5;     // check source freeze time
    localparam int FLASH_MS = 250;   // indicator flash half period
    localparam int TRIP_CYC = CLK_HZ / 1000 * TRIP_MS;
    localparam int FREEZE_CYC = CLK_HZ * FREEZE_S;
    localparam int FLASH_CYC = CLK_HZ / 1000 * FLASH_MS;
    localparam logic FLASH_PHASE_RST = 1'b0;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        RMA_BAR_GREEN = 2'h0,
        RMA_BAR_AMBER = 2'h1,
        RMA_BAR_RED = 2'h3
    } rma_colour_t;

    typedef enum logic [1:0] {
        RMA_DSP_RATE = 2'h0,
        RMA_DSP_ZERO = 2'h1,
        RMA_DSP_ERROR = 2'h3,
        RMA_DSP_SETPT = 2'h2
    } rma_disp_t;

    // setpoints supplied by the setpoint store
    typedef struct packed {
        logic [31:0] warn;
        logic [31:0] high;
        logic [31:0] under;
        logic [31:0] over;
    } rma_setpts_t;

    // front panel buttons, before and after synchronising
    typedef struct packed {
        logic ack;
        logic warn_show;
        logic high_show;
        logic enter;
        logic check;
    } rma_buttons_t;

    // per-alarm indicator drive
    typedef struct packed {
        logic lit;
        logic relay_on;
    } rma_alarm_out_t;

endpackage

// ==== core/rma_alarm_latch.sv ====
// module: one warn or high alarm with acknowledge and fail-safe relay
module rma_alarm_latch (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic over_lim,
    input wire logic hold,
    input wire logic manual_ack,
    input wire logic ack_pulse,
    input wire logic flash_phase,
    output rma_pkg::rma_alarm_out_t out_q
);

    // ****************************************
    // alarm state
    // ****************************************
    logic active_q;
    logic acked_q;

    // latch, acknowledge and clear; frozen while hold
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            active_q <= 1'b0;
            acked_q <= 1'b0;
        end else if (!hold) begin
            if (over_lim) begin
                active_q <= 1'b1;
                if (ack_pulse && active_q) begin
                    acked_q <= 1'b1; // steady while condition stays [RULE_06]
                end
            end else if (!manual_ack || acked_q || ack_pulse) begin
                active_q <= 1'b0; // auto clear or acked clear [RULE_05]
                acked_q <= 1'b0;
            end
        end
    end

    // fail-safe relay: energized when no alarm [RULE_02]
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_q <= '{lit: 1'b0, relay_on: 1'b1};
        end else begin
            out_q.relay_on <= !active_q;
            out_q.lit <= active_q && (acked_q || flash_phase); // flash until acked [RULE_06]
        end
    end

endmodule

// ==== core/rma_alarm_logic.sv ====
// module: ratemeter alarm and annunciation top level
// Behaviour
// [RULE_01] in range show N.NN with unit lit
// [RULE_02] alarm relays energized unless alarm present
// [RULE_03] above warn: flash amber, amber bar, relay off
// [RULE_04] above high: flash red, red bar, relay off
// [RULE_05] jumper selects auto or manual acknowledge
// [RULE_06] ack during alarm: steady lamp, relay off
// [RULE_07] bargraph colour follows present rate
// [RULE_08] warn/high buttons display their setpoint
// [RULE_09] below underrange: show zero, range lamp red
// [RULE_10] underrange setpoint adjustable, default 0.1
// [RULE_11] back above underrange clears range lamp
// [RULE_12] three ranges with bounded setpoint pairs
// [RULE_13] overrange: range lamp, error, red, full-scale
// [RULE_14] overrange clears after return and acknowledge
// [RULE_15] overrange setpoint view lights unit, enter clears
// [RULE_16] anti-jam trip holds fail until fuse replaced
// [RULE_17] fail asserted while any failure detected
// [RULE_18] fail lights lamp, drops fail and aux relays
// [RULE_19] fail clears itself without acknowledge
// [RULE_20] check source active only while held
// [RULE_21] jumper allows or inhibits alarms in check
// [RULE_22] check source forces analog output low
// [RULE_23] alarm trips within one second
// [RULE_24] freeze bar and alarms five seconds at edges
module rma_alarm_logic #(
    parameter int FREEZE_CYCLES = rma_pkg::FREEZE_CYC,
    parameter int FLASH_CYCLES = rma_pkg::FLASH_CYC,
    parameter int TRIP_CYCLES = rma_pkg::TRIP_CYC,
    parameter logic [31:0] UNDER_RESET = rma_pkg::UNDER_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [31:0] rate,
    input wire logic rate_valid,
    input wire rma_pkg::rma_setpts_t setpts,
    input wire logic [31:0] under_wr_data,
    input wire logic under_wr,
    input wire rma_pkg::rma_buttons_t buttons_raw,
    input wire logic manual_ack_jumper,
    input wire logic check_source_alarm_jumper,
    input wire logic anti_jam_fuse_open,
    input wire logic detector_fail,
    input wire logic processor_fail,
    output logic [31:0] disp_value_q,
    output rma_pkg::rma_disp_t disp_mode_q,
    output logic unit_lit_q,
    output rma_pkg::rma_colour_t bar_colour_q,
    output logic [31:0] bar_value_q,
    output logic warn_led_q,
    output logic high_led_q,
    output logic range_led_q,
    output logic fail_led_q,
    output logic check_led_q,
    output logic warn_relay_q,
    output logic high_relay_q,
    output logic fail_relay_q,
    output logic auxiliary_fail_relay_q,
    output logic analog_full_q,
    output logic analog_zero_q,
    output logic [31:0] under_setpt_q
);

    // ****************************************
    // elaboration checks
    // ****************************************
    if (FREEZE_CYCLES < 1 || FLASH_CYCLES < 1 || TRIP_CYCLES < 1) begin : g_bad
        $error("cycle counts must be at least one");
    end

    localparam int CW = $clog2(FREEZE_CYCLES + 1);
    localparam int FW = $clog2(FLASH_CYCLES + 1);

    // ****************************************
    // input synchronisers
    // ****************************************
    rma_pkg::rma_buttons_t btn_s1_q;
    rma_pkg::rma_buttons_t btn_q;
    logic [4:0] cfg_s1_q;
    logic [4:0] cfg_q;
    rma_pkg::rma_buttons_t btn_prev_q;

    // two flops per pin input
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            btn_s1_q <= '0;
            btn_q <= '0;
            cfg_s1_q <= 5'h00;
            cfg_q <= 5'h00;
        end else begin
            btn_s1_q <= buttons_raw;
            btn_q <= btn_s1_q;
            cfg_s1_q <= {manual_ack_jumper, check_source_alarm_jumper, anti_jam_fuse_open,
                         detector_fail, processor_fail};
            cfg_q <= cfg_s1_q;
        end
    end

    // previous levels for press detection
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            btn_prev_q <= '0;
        end else begin
            btn_prev_q <= btn_q;
        end
    end

    logic manual_ack;
    logic chk_alarm_en;
    logic fuse_open;
    logic any_fail;
    logic ack_pulse;
    logic enter_pulse;
    logic show_pulse;
    assign manual_ack = cfg_q[4];
    assign chk_alarm_en = !cfg_q[3]; // jumper in inhibits alarms [RULE_21]
    assign fuse_open = cfg_q[2];
    assign any_fail = cfg_q[1] || cfg_q[0] || fuse_open; // [RULE_17]
    assign ack_pulse = btn_q.ack && !btn_prev_q.ack;
    assign enter_pulse = btn_q.enter && !btn_prev_q.enter;
    assign show_pulse = (btn_q.warn_show && !btn_prev_q.warn_show) ||
                        (btn_q.high_show && !btn_prev_q.high_show);

    // ****************************************
    // underrange setpoint store
    // ****************************************
    // adjustable; writes outside the allowed lower bound span are ignored
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            under_setpt_q <= UNDER_RESET; // [RULE_10]
        end else if (under_wr && under_wr_data >= rma_pkg::UNDER_MIN &&
                     under_wr_data <= rma_pkg::UNDER_MAX) begin
            under_setpt_q <= under_wr_data; // [RULE_12]
        end
    end

    logic [31:0] over_lim_val;
    assign over_lim_val = (setpts.over > rma_pkg::OVER_MAX) ? rma_pkg::OVER_MAX : setpts.over; // [RULE_12]

    // ****************************************
    // rate capture and comparisons
    // ****************************************
    logic [31:0] rate_q;

    // latch each new averaged rate; one cycle, well inside trip time
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rate_q <= 32'h0000_0000;
        end else if (rate_valid) begin
            rate_q <= rate; // [RULE_23]
        end
    end

    logic is_warn;
    logic is_high;
    logic is_under;
    logic is_over;
    assign is_warn = rate_q > setpts.warn;
    assign is_high = rate_q > setpts.high;
    assign is_under = rate_q < under_setpt_q;
    assign is_over = rate_q > over_lim_val;

    // ****************************************
    // check source and freeze timer
    // ****************************************
    logic check_q;
    logic [CW-1:0] freeze_cnt_q;
    logic hold;

    // active only while button held [RULE_20]
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            check_q <= 1'b0;
        end else begin
            check_q <= btn_q.check;
        end
    end

    // reload freeze on entry and exit [RULE_24]
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            freeze_cnt_q <= '0;
        end else if (btn_q.check != check_q) begin
            freeze_cnt_q <= CW'(FREEZE_CYCLES);
        end else if (freeze_cnt_q != '0) begin
            freeze_cnt_q <= freeze_cnt_q - 1'b1;
        end
    end

    assign hold = (freeze_cnt_q != '0) || (btn_q.check != check_q);

    logic alarm_inhibit;
    assign alarm_inhibit = check_q && !chk_alarm_en; // [RULE_21]

    // ****************************************
    // flash generator
    // ****************************************
    logic [FW-1:0] flash_cnt_q;
    logic flash_q;

    // free-running blink for unacknowledged lamps
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flash_cnt_q <= '0;
            flash_q <= rma_pkg::FLASH_PHASE_RST;
        end else if (flash_cnt_q == FW'(FLASH_CYCLES - 1)) begin
            flash_cnt_q <= '0;
            flash_q <= !flash_q;
        end else begin
            flash_cnt_q <= flash_cnt_q + 1'b1;
        end
    end

    // ****************************************
    // warn and high alarms
    // ****************************************
    rma_pkg::rma_alarm_out_t warn_out;
    rma_pkg::rma_alarm_out_t high_out;

    rma_alarm_latch u_warn (
        .clk(clk),
        .rst_b(rst_b),
        .over_lim(is_warn && !alarm_inhibit), // [RULE_03]
        .hold(hold),
        .manual_ack(manual_ack),
        .ack_pulse(ack_pulse),
        .flash_phase(flash_q),
        .out_q(warn_out)
    );

    rma_alarm_latch u_high (
        .clk(clk),
        .rst_b(rst_b),
        .over_lim(is_high && !alarm_inhibit), // [RULE_04]
        .hold(hold),
        .manual_ack(manual_ack),
        .ack_pulse(ack_pulse),
        .flash_phase(flash_q),
        .out_q(high_out)
    );

    // ****************************************
    // overrange latch and unit view flag
    // ****************************************
    logic over_q;
    logic over_unit_q;

    // hold until back in range and acknowledged [RULE_14]
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            over_q <= 1'b0;
        end else if (is_over) begin
            over_q <= 1'b1; // [RULE_13]
        end else if (ack_pulse) begin
            over_q <= 1'b0;
        end
    end

    // setpoint view in overrange lights units; set wins over enter [RULE_15]
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            over_unit_q <= 1'b0;
        end else if (over_q && show_pulse) begin
            over_unit_q <= 1'b1;
        end else if (enter_pulse) begin
            over_unit_q <= 1'b0;
        end
    end

    // ****************************************
    // display
    // ****************************************
    // priority: overrange, setpoint view, underrange, rate
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            disp_mode_q <= rma_pkg::RMA_DSP_RATE;
            disp_value_q <= 32'h0000_0000;
            unit_lit_q <= 1'b0;
        end else if (over_q) begin
            disp_mode_q <= rma_pkg::RMA_DSP_ERROR; // [RULE_13]
            disp_value_q <= 32'h0000_0000;
            unit_lit_q <= over_unit_q; // [RULE_15]
        end else if (btn_q.high_show || btn_q.warn_show) begin
            disp_mode_q <= rma_pkg::RMA_DSP_SETPT; // [RULE_08]
            disp_value_q <= btn_q.high_show ? setpts.high : setpts.warn;
            unit_lit_q <= 1'b1;
        end else if (is_under) begin
            disp_mode_q <= rma_pkg::RMA_DSP_ZERO; // [RULE_09]
            disp_value_q <= 32'h0000_0000;
            unit_lit_q <= 1'b1;
        end else begin
            disp_mode_q <= rma_pkg::RMA_DSP_RATE; // [RULE_01]
            disp_value_q <= rate_q;
            unit_lit_q <= 1'b1;
        end
    end

    // ****************************************
    // bargraph
    // ****************************************
    // colour tracks present rate, frozen around check source
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bar_colour_q <= rma_pkg::RMA_BAR_GREEN;
            bar_value_q <= 32'h0000_0000;
        end else if (!hold) begin
            bar_value_q <= rate_q; // actual value even underrange [RULE_09]
            if (is_high || over_q) begin
                bar_colour_q <= rma_pkg::RMA_BAR_RED; // [RULE_07] [RULE_13]
            end else if (is_warn) begin
                bar_colour_q <= rma_pkg::RMA_BAR_AMBER; // [RULE_07]
            end else begin
                bar_colour_q <= rma_pkg::RMA_BAR_GREEN; // [RULE_07]
            end
        end
    end

    // ****************************************
    // indicators and relays
    // ****************************************
    // alarm lamps and fail-safe relays
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            warn_led_q <= 1'b0;
            high_led_q <= 1'b0;
            warn_relay_q <= 1'b1;
            high_relay_q <= 1'b1;
        end else begin
            warn_led_q <= warn_out.lit && !check_q;
            high_led_q <= high_out.lit && !check_q;
            warn_relay_q <= warn_out.relay_on; // [RULE_02]
            high_relay_q <= high_out.relay_on; // [RULE_02]
        end
    end

    // range lamp: underrange clears by itself [RULE_11]
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            range_led_q <= 1'b0;
        end else begin
            range_led_q <= is_under || over_q; // [RULE_09] [RULE_13]
        end
    end

    // fail follows live fault; fuse input stays open until replaced [RULE_16]
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fail_led_q <= 1'b0;
            fail_relay_q <= 1'b1;
            auxiliary_fail_relay_q <= 1'b1;
        end else begin
            fail_led_q <= any_fail; // [RULE_18] [RULE_19]
            fail_relay_q <= !any_fail; // [RULE_18]
            auxiliary_fail_relay_q <= !any_fail; // parallel to fail relay [RULE_18]
        end
    end

    // check lamp and analog overrides
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            check_led_q <= 1'b0;
            analog_full_q <= 1'b0;
            analog_zero_q <= 1'b0;
        end else begin
            check_led_q <= check_q; // [RULE_20]
            analog_zero_q <= check_q; // [RULE_22]
            analog_full_q <= over_q && !check_q; // [RULE_13]
        end
    end

endmodule

// ==== verif/rma_alarm_sva.sv ====
// checker: concurrent assertions on the alarm logic top ports
module rma_alarm_sva (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic under_wr,
    input wire logic [31:0] under_wr_data,
    input wire rma_pkg::rma_buttons_t buttons_raw,
    input wire logic anti_jam_fuse_open,
    input wire logic detector_fail,
    input wire logic processor_fail,
    input wire logic [31:0] disp_value_q,
    input wire rma_pkg::rma_disp_t disp_mode_q,
    input wire logic range_led_q,
    input wire logic fail_led_q,
    input wire logic check_led_q,
    input wire logic fail_relay_q,
    input wire logic auxiliary_fail_relay_q,
    input wire logic analog_zero_q,
    input wire logic [31:0] under_setpt_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // any failure source, levels
    wire any_fail = detector_fail | processor_fail | anti_jam_fuse_open;
    // ****************************************
    // input histories
    // ****************************************
    sequence fail_held; any_fail [*6]; endsequence
    sequence fail_gone; !any_fail [*6]; endsequence
    sequence check_held; buttons_raw.check [*5]; endsequence
    sequence check_gone; !buttons_raw.check [*5]; endsequence
    // ****************************************
    // assertions
    // ****************************************
    fail_drop_a: assert property (fail_held |-> !fail_relay_q)
        else $error("fail relay still energized");
    fail_clear_a: assert property (fail_gone |-> fail_relay_q)
        else $error("fail relay not restored");
    aux_follow_a: assert property (auxiliary_fail_relay_q == fail_relay_q)
        else $error("aux relay differs from fail relay");
    fail_lamp_a: assert property (fail_led_q == !fail_relay_q)
        else $error("fail lamp differs from fail relay");
    check_lamp_a: assert property (check_held |-> check_led_q)
        else $error("check lamp dark while held");
    check_off_a: assert property (check_gone |-> !check_led_q)
        else $error("check lamp lit after release");
    analog_low_a: assert property (check_held |-> analog_zero_q)
        else $error("analog not low in check");
    error_range_a: assert property (disp_mode_q == rma_pkg::RMA_DSP_ERROR |-> range_led_q)
        else $error("error display without range lamp");
    zero_show_a: assert property (disp_mode_q == rma_pkg::RMA_DSP_ZERO |-> range_led_q && disp_value_q == 32'h0)
        else $error("zero display wrong");
    under_ok_a: assert property (under_wr && under_wr_data == 32'h64 |-> ##[1:3] under_setpt_q == 32'h64)
        else $error("underrange write lost");
    under_bad_a: assert property (under_wr && under_wr_data > 32'h64 |=> $stable(under_setpt_q))
        else $error("bad underrange write taken");
endmodule

// ==== verif/rma_panel_model.sv ====
// model: detector rate source and operator front panel
module rma_panel_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [31:0] rate_req,
    input wire rma_pkg::rma_buttons_t press,
    output logic [31:0] rate,
    output logic rate_valid,
    output rma_pkg::rma_buttons_t buttons_raw
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] tick_q;
    // update every fourth cycle, inverted junk between updates
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_q <= 2'h0;
            rate_valid <= 1'b0;
            rate <= 32'h0;
        end else begin
            tick_q <= tick_q + 2'h1;
            rate_valid <= (tick_q == 2'h3);
            rate <= (tick_q == 2'h3) ? rate_req : ~rate_req;
        end
    end
    // operator holds each button as a level while asked
    assign buttons_raw = press;
endmodule

// ==== verif/test_rma_alarm_logic.sv ====
// testbench: alarm logic against a behavioural model
module test_rma_alarm_logic;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] WARN = 32'h0000_03E8;
    localparam logic [31:0] HIGH = 32'h0000_1388;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [31:0] rate_req = 32'h64;
    rma_pkg::rma_buttons_t btn = '0;
    rma_pkg::rma_setpts_t setpts = '{warn: WARN, high: HIGH, under: 32'hA, over: rma_pkg::OVER_DEFAULT};
    logic [31:0] rate, under_wr_data = 32'h0, disp_value_q, bar_value_q, under_setpt_q;
    logic rate_valid, under_wr = 1'b0, manual_ack_jumper = 1'b0, check_source_alarm_jumper = 1'b1;
    logic anti_jam_fuse_open = 1'b0, detector_fail = 1'b0, processor_fail = 1'b0;
    rma_pkg::rma_buttons_t buttons_raw;
    rma_pkg::rma_disp_t disp_mode_q;
    rma_pkg::rma_colour_t bar_colour_q;
    logic unit_lit_q, warn_led_q, high_led_q, range_led_q, fail_led_q, check_led_q, warn_relay_q;
    logic high_relay_q, fail_relay_q, auxiliary_fail_relay_q, analog_full_q, analog_zero_q;
    int failures = 0, total_checks = 0, m_man = 0, m_over = 0, m_under = 10, n;
    int m_al[2] = '{0, 0}, m_ak[2] = '{0, 0}, base[5] = '{1, 50, 1500, 6000, 150000};
    int span[5] = '{9, 900, 3000, 90000, 100000};
    logic [7:0] seed = 8'h51;
    rma_panel_model panel (.clk, .rst_b, .rate_req, .press(btn), .rate, .rate_valid, .buttons_raw);
    rma_alarm_logic #(.FREEZE_CYCLES(20), .FLASH_CYCLES(4), .TRIP_CYCLES(25),
        .UNDER_RESET(rma_pkg::UNDER_DEFAULT)) uut (.clk, .rst_b, .rate, .rate_valid, .setpts,
        .under_wr_data, .under_wr, .buttons_raw, .manual_ack_jumper, .check_source_alarm_jumper,
        .anti_jam_fuse_open, .detector_fail, .processor_fail, .disp_value_q, .disp_mode_q, .unit_lit_q,
        .bar_colour_q, .bar_value_q, .warn_led_q, .high_led_q, .range_led_q, .fail_led_q, .check_led_q,
        .warn_relay_q, .high_relay_q, .fail_relay_q, .auxiliary_fail_relay_q, .analog_full_q,
        .analog_zero_q, .under_setpt_q);
    // ****************************************
    // helpers and model
    // ****************************************
    function automatic logic [7:0] lfsr(logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic tick(int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic push(int b);
        btn[b] = 1'b1;
        tick(6);
        btn[b] = 1'b0;
        tick(12);
    endtask
    task automatic wr_under(logic [31:0] d);
        under_wr_data = d;
        under_wr = 1'b1;
        tick(1);
        under_wr = 1'b0;
        tick(3);
    endtask
    // drive a rate, optionally acknowledge, then compare with the model
    task automatic apply(int r, bit ack);
        int lim[2] = '{WARN, HIGH};
        rate_req = r;
        tick(12);
        if (ack) push(4);
        for (int i = 0; i < 2; i++) begin
            if (r > lim[i]) begin
                m_al[i] = 1;
                m_ak[i] = m_ak[i] | ack;
            end else if (m_man == 0 || m_ak[i] != 0 || ack) begin
                m_al[i] = 0;
                m_ak[i] = 0;
            end
        end
        if (r > rma_pkg::OVER_DEFAULT) m_over = 1;
        else if (ack) m_over = 0;
        cmp("warn relay", m_al[0] == 0, warn_relay_q);
        cmp("high relay", m_al[1] == 0, high_relay_q);
        cmp("range lamp", m_over != 0 || r < m_under, range_led_q);
        cmp("analog full", m_over != 0, analog_full_q);
        if (m_over != 0) cmp("display mode", rma_pkg::RMA_DSP_ERROR, disp_mode_q);
        else if (r < m_under) cmp("display mode", rma_pkg::RMA_DSP_ZERO, disp_mode_q);
        else cmp("display value", r, disp_value_q);
        if (m_over == 0 && r >= m_under) cmp("unit lamp", 1, unit_lit_q);
        if (m_over == 0) cmp("bar value", r, bar_value_q);
        if (m_over == 0) cmp("bar colour", r > HIGH ? 3 : r > WARN ? 1 : 0, bar_colour_q);
        if (m_ak[1] | !m_al[1]) cmp("high lamp", m_ak[1], high_led_q);
    endtask
    task automatic close_out();
        if (failures == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ****************************************
    // clock, watchdog, main sequence
    // ****************************************
    initial forever #20 clk = ~clk;
    initial begin
        repeat (30000) @(posedge clk);
        failures++;
        close_out();
    end
    initial begin
        tick(4);
        rst_b = 1'b1;
        cmp("warn relay", 1, warn_relay_q);
        cmp("underrange", 32'hA, under_setpt_q);
        for (int p = 0; p < 2; p++) begin
            m_man = p;
            manual_ack_jumper = p[0];
            apply(100, 1);
            for (int j = 0; j < 10; j++) begin
                seed = lfsr(seed);
                n = seed % 5;
                seed = lfsr(seed);
                apply(base[n] + seed % span[n], seed[0]);
            end
        end
        apply(100, 1);
        apply(2000, 0);
        n = 0;
        for (int i = 0; i < 10; i++) begin
            tick(1);
            n += warn_led_q;
        end
        cmp("warn flashing", 1, n > 0 && n < 10);
        apply(2000, 1);
        n = 0;
        for (int i = 0; i < 10; i++) begin
            tick(1);
            n += warn_led_q;
        end
        cmp("warn steady", 10, n);
        apply(100, 0);
        cmp("warn lamp", 0, warn_led_q);
        for (int b = 2; b < 4; b++) begin
            btn[b] = 1'b1;
            tick(8);
            cmp("display mode", rma_pkg::RMA_DSP_SETPT, disp_mode_q);
            cmp("display value", b == 3 ? WARN : HIGH, disp_value_q);
            btn[b] = 1'b0;
            tick(8);
        end
        apply(200000, 0);
        push(3);
        cmp("unit lamp", 1, unit_lit_q);
        cmp("display mode", rma_pkg::RMA_DSP_ERROR, disp_mode_q);
        push(1);
        cmp("unit lamp", 0, unit_lit_q);
        apply(100, 0);
        apply(100, 1);
        wr_under(32'h64);
        cmp("underrange", 32'h64, under_setpt_q);
        m_under = 100;
        apply(80, 0);
        apply(150, 0);
        wr_under(32'h65);
        wr_under(32'h0);
        cmp("underrange", 32'h64, under_setpt_q);
        wr_under(32'hA);
        m_under = 10;
        for (int f = 0; f < 3; f++) begin
            {anti_jam_fuse_open, processor_fail, detector_fail} = 3'(1 << f);
            tick(8);
            cmp("fail relay", 0, fail_relay_q);
            cmp("aux relay", 0, auxiliary_fail_relay_q);
            cmp("fail lamp", 1, fail_led_q);
            {anti_jam_fuse_open, processor_fail, detector_fail} = 3'h0;
            tick(8);
            cmp("fail relay", 1, fail_relay_q);
        end
        manual_ack_jumper = 1'b0;
        m_man = 0;
        apply(100, 1);
        for (int jp = 0; jp < 2; jp++) begin
            check_source_alarm_jumper = jp[0];
            btn[0] = 1'b1;
            rate_req = 2000;
            tick(10);
            cmp("check lamp", 1, check_led_q);
            cmp("analog low", 1, analog_zero_q);
            cmp("bar colour", 0, bar_colour_q);
            tick(40);
            cmp("bar colour", 1, bar_colour_q);
            cmp("warn relay", jp, warn_relay_q);
            btn[0] = 1'b0;
            rate_req = 100;
            tick(40);
            cmp("check lamp", 0, check_led_q);
            cmp("bar colour", 0, bar_colour_q);
            apply(100, 1);
        end
        close_out();
    end
endmodule

bind rma_alarm_logic rma_alarm_sva chk (.clk, .rst_b, .under_wr, .under_wr_data, .buttons_raw,
    .anti_jam_fuse_open, .detector_fail, .processor_fail, .disp_value_q, .disp_mode_q, .range_led_q,
    .fail_led_q, .check_led_q, .fail_relay_q, .auxiliary_fail_relay_q, .analog_zero_q, .under_setpt_q);
